// ### rtl/serial_link_engine.sv
`timescale 1ns/1ps
// Overview of operation
// - four identical links, one rx one tx
// - every sent byte acknowledged on same link
// - idle output line held low
// - data packet: start, one, eight bits, stop
// - data bits sent and assembled lsb first
// - wait for ack: start then zero
// - ack only when byte and next accepted
// - release sender only after each byte's ack
// - rates 10, 5 and 20 mbit/s
// - timing independent of clock phase
// - global strap plus per-group strap selects rate
// - strap code 00/10=10, 01=5, 11=20
// - 5 mbit/s only on fastest grades
module serial_link_engine #(
    parameter int unsigned LINKS = serial_link_pkg::NUM_LINKS
) (
    input  wire logic                                           mclk,
    input  wire logic                                           rst,
    serial_link_if.device                                       link,
    input  wire logic                                           global_rate_strap,
    input  wire logic                                           first_port_rate_strap,
    input  wire logic                                           other_ports_rate_strap,
    input  wire logic [LINKS-1:0]                               tx_valid,
    input  wire logic [LINKS-1:0][serial_link_pkg::DATA_BITS-1:0] tx_data,
    input  wire logic [LINKS-1:0]                               tx_last,
    output logic      [LINKS-1:0]                               tx_ready,
    output logic      [LINKS-1:0]                               tx_done,
    output logic      [LINKS-1:0]                               rx_valid,
    output logic      [LINKS-1:0][serial_link_pkg::DATA_BITS-1:0] rx_data,
    input  wire logic [LINKS-1:0]                               rx_ready
);
    // ----------------------------------------------------------------
    // strap synchronisers and rate select
    // ----------------------------------------------------------------
    logic [2:0] strap_s1_q, strap_s2_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
        end else begin
            strap_s1_q <= {global_rate_strap, first_port_rate_strap, other_ports_rate_strap};
            strap_s2_q <= strap_s1_q;
        end
    end

    genvar g;
    for (g = 0; g < LINKS; g++) begin : g_link
        logic grp;
        logic [serial_link_pkg::DIV_W-1:0] period;
        assign grp    = (g == 0) ? strap_s2_q[1] : strap_s2_q[0];
        assign period = serial_link_pkg::bit_period(strap_s2_q[2], grp);

        // ------------------------------------------------------------
        // receive line sync
        // ------------------------------------------------------------
        logic rx_s1_q, rx_s2_q;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                rx_s1_q <= 1'b0;
                rx_s2_q <= 1'b0;
            end else begin
                rx_s1_q <= link.peer_to_dev[g];
                rx_s2_q <= rx_s1_q;
            end
        end

        // ------------------------------------------------------------
        // receiver
        // ------------------------------------------------------------
        serial_link_pkg::rx_state_type rs_q, rs_d;
        logic [serial_link_pkg::DIV_W-1:0] rtim_q, rtim_d;
        logic [serial_link_pkg::CNT_W-1:0] rcnt_q, rcnt_d;
        logic [serial_link_pkg::DATA_BITS-1:0] rsh_q, rsh_d;
        logic rvalid_q, rvalid_d, ack_req_q, ack_req_d, ack_pend_q, ack_pend_d;
        logic ack_seen;
        logic [serial_link_pkg::DATA_BITS-1:0] rdata_q, rdata_d;
        always_comb begin
            rs_d = rs_q; rtim_d = rtim_q; rcnt_d = rcnt_q; rsh_d = rsh_q;
            rvalid_d = rvalid_q; rdata_d = rdata_q; ack_pend_d = ack_pend_q;
            ack_req_d = 1'b0; ack_seen = 1'b0;
            if (rvalid_q && rx_ready[g]) rvalid_d = 1'b0;
            // ack once the byte is taken; a byte ending now sets the flag again
            if (ack_pend_q && !rvalid_q) begin
                ack_req_d  = 1'b1;
                ack_pend_d = 1'b0;
            end
            unique case (rs_q)
                serial_link_pkg::RX_IDLE: if (rx_s2_q == serial_link_pkg::START_BIT) begin
                    rs_d = serial_link_pkg::RX_FLAG;
                    rtim_d = period + (period >> 1) - 1'b1;
                end
                serial_link_pkg::RX_FLAG: if (rtim_q == '0) begin
                    rtim_d = period - 1'b1; rcnt_d = '0;
                    if (rx_s2_q == serial_link_pkg::DATA_FLAG) rs_d = serial_link_pkg::RX_DATA;
                    else begin
                        ack_seen = 1'b1;
                        rs_d = serial_link_pkg::RX_STOP;
                        rtim_d = period >> 1;
                    end
                end else rtim_d = rtim_q - 1'b1;
                serial_link_pkg::RX_DATA: if (rtim_q == '0) begin
                    rtim_d = period - 1'b1;
                    rsh_d = {rx_s2_q, rsh_q[serial_link_pkg::DATA_BITS-1:1]};
                    rcnt_d = rcnt_q + 1'b1;
                    if (rcnt_q == serial_link_pkg::LAST_DATA_BIT) begin
                        rs_d = serial_link_pkg::RX_STOP;
                        rdata_d = {rx_s2_q, rsh_q[serial_link_pkg::DATA_BITS-1:1]};
                        rvalid_d = 1'b1;
                        ack_pend_d = 1'b1;
                    end
                end else rtim_d = rtim_q - 1'b1;
                serial_link_pkg::RX_STOP: if (rtim_q == '0) begin
                    if (rx_s2_q == serial_link_pkg::STOP_BIT) rs_d = serial_link_pkg::RX_IDLE;
                end else rtim_d = rtim_q - 1'b1;
            endcase
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                rs_q <= serial_link_pkg::RX_IDLE; rtim_q <= '0; rcnt_q <= '0; rsh_q <= '0;
                rvalid_q <= 1'b0; rdata_q <= '0; ack_pend_q <= 1'b0; ack_req_q <= 1'b0;
            end else begin
                rs_q <= rs_d; rtim_q <= rtim_d; rcnt_q <= rcnt_d; rsh_q <= rsh_d;
                rvalid_q <= rvalid_d; rdata_q <= rdata_d; ack_req_q <= ack_req_d;
                ack_pend_q <= ack_pend_d;
            end
        end

        // ------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------
        serial_link_pkg::tx_state_type ts_q, ts_d;
        logic [serial_link_pkg::DIV_W-1:0] ttim_q, ttim_d;
        logic [serial_link_pkg::CNT_W-1:0] tcnt_q, tcnt_d;
        logic [serial_link_pkg::DATA_BITS-1:0] tsh_q, tsh_d;
        logic line_q, line_d, is_ack_q, is_ack_d, last_q, last_d;
        logic ack_due_q, ack_due_d, ack_got_q, ack_got_d, rdy_q, rdy_d, done_q, done_d;
        logic tick;
        assign tick = (ttim_q == '0);
        always_comb begin
            ts_d = ts_q; ttim_d = tick ? '0 : ttim_q - 1'b1; tcnt_d = tcnt_q; tsh_d = tsh_q;
            line_d = line_q; is_ack_d = is_ack_q; last_d = last_q; done_d = 1'b0;
            ack_due_d = ack_due_q | ack_req_q;
            ack_got_d = ack_got_q | ack_seen;
            rdy_d = 1'b0;
            unique case (ts_q)
                serial_link_pkg::TX_IDLE: begin
                    line_d = serial_link_pkg::LINE_IDLE;
                    if (ack_due_d) begin
                        ack_due_d = 1'b0; is_ack_d = 1'b1;
                        ts_d = serial_link_pkg::TX_START; ttim_d = period - 1'b1;
                        line_d = serial_link_pkg::START_BIT;
                    end else if (tx_valid[g] && rdy_q) begin
                        is_ack_d = 1'b0; tsh_d = tx_data[g]; last_d = tx_last[g];
                        ts_d = serial_link_pkg::TX_START; ttim_d = period - 1'b1;
                        line_d = serial_link_pkg::START_BIT;
                    end else rdy_d = 1'b1;
                end
                serial_link_pkg::TX_START: if (tick) begin
                    ts_d = serial_link_pkg::TX_FLAG; ttim_d = period - 1'b1;
                    line_d = is_ack_q ? serial_link_pkg::ACK_FLAG : serial_link_pkg::DATA_FLAG;
                end
                serial_link_pkg::TX_FLAG: if (tick) begin
                    ttim_d = period - 1'b1; tcnt_d = '0;
                    if (is_ack_q) begin
                        ts_d = serial_link_pkg::TX_IDLE; line_d = serial_link_pkg::LINE_IDLE;
                    end else begin
                        ts_d = serial_link_pkg::TX_DATA; line_d = tsh_q[0];
                    end
                end
                serial_link_pkg::TX_DATA: if (tick) begin
                    ttim_d = period - 1'b1; tcnt_d = tcnt_q + 1'b1;
                    tsh_d = tsh_q >> 1;
                    if (tcnt_q == serial_link_pkg::LAST_DATA_BIT) begin
                        ts_d = serial_link_pkg::TX_STOP; line_d = serial_link_pkg::STOP_BIT;
                    end else line_d = tsh_q[1];
                end
                serial_link_pkg::TX_STOP: if (tick) begin
                    ts_d = serial_link_pkg::TX_ACK; ack_got_d = ack_seen;
                end
                serial_link_pkg::TX_ACK: begin
                    line_d = serial_link_pkg::LINE_IDLE;
                    if (ack_got_q) begin
                        ack_got_d = ack_seen; ts_d = serial_link_pkg::TX_IDLE;
                        done_d = last_q;
                    end
                end
                default: ts_d = serial_link_pkg::TX_IDLE;
            endcase
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                ts_q <= serial_link_pkg::TX_IDLE; ttim_q <= '0; tcnt_q <= '0; tsh_q <= '0;
                line_q <= 1'b0; is_ack_q <= 1'b0; last_q <= 1'b0; ack_due_q <= 1'b0;
                ack_got_q <= 1'b0; rdy_q <= 1'b0; done_q <= 1'b0;
            end else begin
                ts_q <= ts_d; ttim_q <= ttim_d; tcnt_q <= tcnt_d; tsh_q <= tsh_d;
                line_q <= line_d; is_ack_q <= is_ack_d; last_q <= last_d;
                ack_due_q <= ack_due_d; ack_got_q <= ack_got_d; rdy_q <= rdy_d;
                done_q <= done_d;
            end
        end
        assign link.dev_to_peer[g] = line_q;
        assign tx_ready[g]         = rdy_q;
        assign tx_done[g]          = done_q;
        assign rx_valid[g]         = rvalid_q;
        assign rx_data[g]          = rdata_q;
    end
endmodule : serial_link_engine

// ### rtl/serial_link_pkg.sv
package serial_link_pkg;
    // ----------------------------------------------------------------
    // clock and line rates
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned RATE_STD_MBPS  = 10;
    localparam int unsigned RATE_SLOW_MBPS = 5;
    localparam int unsigned RATE_FAST_MBPS = 20;
    localparam int unsigned DIV_W          = 8;
    localparam logic [DIV_W-1:0] DIV_STD   = DIV_W'(CLK_MHZ / RATE_STD_MBPS);
    localparam logic [DIV_W-1:0] DIV_SLOW  = DIV_W'(CLK_MHZ / RATE_SLOW_MBPS);
    localparam logic [DIV_W-1:0] DIV_FAST  = DIV_W'(CLK_MHZ / RATE_FAST_MBPS);
    // ----------------------------------------------------------------
    // packet format
    // ----------------------------------------------------------------
    localparam int unsigned NUM_LINKS  = 4;
    localparam int unsigned DATA_BITS  = 8;
    localparam int unsigned CNT_W      = 4;
    localparam logic [CNT_W-1:0] LAST_DATA_BIT = CNT_W'(DATA_BITS - 1);
    localparam logic       LINE_IDLE   = 1'b0;
    localparam logic       START_BIT   = 1'b1;
    localparam logic       DATA_FLAG   = 1'b1;
    localparam logic       ACK_FLAG    = 1'b0;
    localparam logic       STOP_BIT    = 1'b0;
    // ----------------------------------------------------------------
    // states and helpers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_FLAG  = 3'h3,
        TX_DATA  = 3'h2,
        TX_STOP  = 3'h6,
        TX_ACK   = 3'h7
    } tx_state_type;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_FLAG = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } rx_state_type;

    function automatic logic [DIV_W-1:0] bit_period(input logic glob, input logic grp);
        unique case ({glob, grp})
            2'b01:   bit_period = DIV_SLOW;
            2'b11:   bit_period = DIV_FAST;
            default: bit_period = DIV_STD;
        endcase
    endfunction : bit_period
endpackage : serial_link_pkg

// ### rtl/serial_link_if.sv
`timescale 1ns/1ps
interface serial_link_if;
    logic [serial_link_pkg::NUM_LINKS-1:0] dev_to_peer;
    logic [serial_link_pkg::NUM_LINKS-1:0] peer_to_dev;
    modport device (output dev_to_peer, input peer_to_dev);
    modport peer   (input dev_to_peer, output peer_to_dev);
endinterface : serial_link_if

// ### rtl/serial_link_peer.sv
`timescale 1ns/1ps
// peer end: quiet model facing the other modport, drives every line low
module serial_link_peer (
    input  wire logic mclk,
    input  wire logic rst,
    serial_link_if.peer link,
    input  wire logic global_rate_strap,
    input  wire logic first_port_rate_strap,
    input  wire logic other_ports_rate_strap
);
    // ----------------------------------------------------------------
    // peer transmits idle low and echoes nothing; the testbench drives data
    // ----------------------------------------------------------------
    logic [serial_link_pkg::NUM_LINKS-1:0] line_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) line_q <= '0;
        else line_q <= '0;
    end
    assign link.peer_to_dev = line_q;
endmodule : serial_link_peer

// ### dv/serial_link_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// line checks on link 0 of the engine facing the quiet peer; the reset check covers all four lines both ways
// ------------------------------------------------------------
module serial_link_checker #(
    parameter int BIT_P = 25
) (
    input wire logic                                  mclk,
    input wire logic                                  rst,
    input wire logic [serial_link_pkg::NUM_LINKS-1:0] dev_to_peer,
    input wire logic [serial_link_pkg::NUM_LINKS-1:0] peer_to_dev
);
    localparam int P1   = BIT_P - 1;
    localparam int MID  = BIT_P + BIT_P / 2;
    localparam int REST = 9 * BIT_P;
    localparam int MAXH = 10 * BIT_P;
    localparam int FRAME = 11 * BIT_P;
    logic [9:0] pos_q, pos_d;
    logic       sof;
    logic       line;
    logic       line_q;
    logic [7:0] ph_q, ph_d;
    logic [9:0] hi_q, hi_d;
    logic [1:0] pk_q, pk_d;
    assign line = dev_to_peer[0];
    // packet start: a rising edge while no packet is in flight
    assign sof  = line && !line_q && pos_q == 10'h000;
    always_comb begin
        ph_d = (ph_q == 8'(P1)) ? 8'h00 : ph_q + 8'h01;
        if (line && !line_q) begin
            ph_d = 8'h01;
        end
        hi_d = line ? hi_q + 10'h001 : 10'h000;
        pk_d = (sof && pk_q != 2'h3) ? pk_q + 2'h1 : pk_q;
        if (pos_q != 10'h000) begin
            pos_d = (pos_q == 10'(FRAME - 1)) ? 10'h000 : pos_q + 10'h001;
        end else begin
            pos_d = sof ? 10'h001 : 10'h000;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {line_q, ph_q, hi_q, pk_q, pos_q} <= '0;
        end else begin
            {line_q, ph_q, hi_q, pk_q, pos_q} <= {line, ph_d, hi_d, pk_d, pos_d};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence data_head;
        sof ##MID line;
    endsequence
    a_idle_after_rst: assert property (
        $fell(rst) |-> dev_to_peer == 4'h0 && peer_to_dev == 4'h0) else $error("line busy after reset");
    a_start_min: assert property (sof |-> line [*8])
        else $error("start bit too short");
    a_start_full: assert property (sof |-> ##P1 line)
        else $error("start bit not one period");
    a_stop_after: assert property (data_head |-> ##REST !line)
        else $error("stop bit missing");
    a_no_ack_sent: assert property (sof |-> ##MID line)
        else $error("ack sent without received byte");
    a_bit_edges: assert property ($changed(line) |-> $rose(line) || ph_q == 8'h00)
        else $error("line changed inside a bit");
    a_high_bound: assert property (hi_q < 10'(MAXH))
        else $error("line high too long");
    a_wait_ack: assert property (pk_q <= 2'h1)
        else $error("second packet without ack");
endmodule : serial_link_checker

// ### dv/serial_link_engine_tb.sv
`timescale 1ns/1ps
module serial_link_engine_tb;
    logic            mclk, rst, sa, glob, grp0, grp1, va;
    logic [3:0]      valid_b, last_b, rxr_b, rdy_b, done_b, rxv_b, bl_in, bl_out, rdy_a, done_a;
    logic [3:0][7:0] txd, rxd;
    int              n_errors, n_compared, per, n;
    serial_link_if serial_link_if_i ();
    serial_link_if serial_link_if_b_i ();
    assign serial_link_if_b_i.peer_to_dev = bl_in;
    assign bl_out = serial_link_if_b_i.dev_to_peer;
    always #2 mclk = ~mclk;
    serial_link_engine serial_link_engine_i (.mclk(mclk), .rst(rst), .link(serial_link_if_i.device),
        .global_rate_strap(sa), .first_port_rate_strap(sa), .other_ports_rate_strap(sa),
        .tx_valid({3'h0, va}), .tx_data(txd), .tx_last(last_b), .tx_ready(rdy_a),
        .tx_done(done_a), .rx_valid(), .rx_data(), .rx_ready(4'hf));
    serial_link_peer serial_link_peer_i (.mclk(mclk), .rst(rst), .link(serial_link_if_i.peer),
        .global_rate_strap(sa), .first_port_rate_strap(sa), .other_ports_rate_strap(sa));
    serial_link_checker #(.BIT_P(25)) serial_link_checker_i (.mclk(mclk), .rst(rst),
        .dev_to_peer(serial_link_if_i.dev_to_peer), .peer_to_dev(serial_link_if_i.peer_to_dev));
    serial_link_engine serial_link_engine_b_i (.mclk(mclk), .rst(rst),
        .link(serial_link_if_b_i.device), .global_rate_strap(glob), .first_port_rate_strap(grp0),
        .other_ports_rate_strap(grp1), .tx_valid(valid_b), .tx_data(txd), .tx_last(last_b),
        .tx_ready(rdy_b), .tx_done(done_b), .rx_valid(rxv_b), .rx_data(rxd), .rx_ready(rxr_b));
    // ------------------------------------------------------------
    // compare, report and line tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_sim();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic tmo(input int lim);
        if (n >= lim) begin
            n_errors++;
            end_sim();
        end
    endtask : tmo
    task automatic grab(input int l, input int cnt, output logic [15:0] v);
        v = 16'h0000;
        for (n = 0; n < 200 && bl_out[l] !== 1'b1; n++) @(negedge mclk);
        tmo(200);
        repeat (per / 2) @(negedge mclk);
        for (int i = 0; i < cnt; i++) begin
            v[i] = bl_out[l];
            repeat (per) @(negedge mclk);
        end
    endtask : grab
    task automatic put(input int l, input logic [15:0] v, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge mclk) bl_in[l] <= v[i];
            repeat (per - 1) @(posedge mclk);
        end
        @(posedge mclk) bl_in[l] <= 1'b0;
    endtask : put
    task automatic tx_byte(input int l, input logic [7:0] d, input logic lst);
        logic [15:0] v;
        logic        seen;
        for (n = 0; n < 400 && rdy_b[l] !== 1'b1; n++) @(negedge mclk);
        tmo(400);
        @(posedge mclk) begin valid_b[l] <= 1'b1; txd[l] <= d; last_b[l] <= lst; end
        @(posedge mclk) valid_b[l] <= 1'b0;
        grab(l, 11, v);
        cmp(v, {5'h00, 1'b0, d, 2'h3});
        cmp({15'h0000, rdy_b[l]}, 16'h0000);
        seen = 1'b0;
        fork
            put(l, 16'h0001, 2);
            for (n = 0; n < 400 && rdy_b[l] !== 1'b1; n++) begin
                @(negedge mclk);
                seen = seen | done_b[l];
            end
        join
        tmo(400);
        repeat (3) begin @(negedge mclk); seen = seen | done_b[l]; end
        cmp({15'h0000, seen}, {15'h0000, lst});
    endtask : tx_byte
    task automatic rx_byte(input int l, input logic [7:0] d);
        logic [15:0] v;
        put(l, {5'h00, 1'b0, d, 2'h3}, 11);
        for (n = 0; n < 100 && rxv_b[l] !== 1'b1; n++) @(negedge mclk);
        tmo(100);
        cmp({8'h00, rxd[l]}, {8'h00, d});
        v = 16'h0000;
        repeat (3 * per) begin @(negedge mclk); v[0] = v[0] | bl_out[l]; end
        cmp(v, 16'h0000);
        @(posedge mclk) rxr_b[l] <= 1'b1;
        @(posedge mclk) rxr_b[l] <= 1'b0;
        grab(l, 2, v);
        cmp(v, 16'h0001);
    endtask : rx_byte
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0; rst = 1'b1; sa = 1'b0; glob = 1'b0; grp0 = 1'b0; grp1 = 1'b0; va = 1'b0;
        valid_b = 4'h0; last_b = 4'h0; rxr_b = 4'h0; bl_in = 4'h0; txd = '0;
        n_errors = 0; n_compared = 0; per = 25; n = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(negedge mclk);
        cmp({8'h00, rdy_b, bl_out}, 16'h00f0);
        @(posedge mclk) begin va <= 1'b1; txd[0] <= 8'h5a; last_b[0] <= 1'b1; end
        @(posedge mclk) va <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk) begin glob <= c[1]; grp0 <= c[0]; grp1 <= c[0]; end
            per = serial_link_pkg::CLK_MHZ / ((c == 1) ? 5 : (c == 3) ? 20 : 10);
            repeat (4) @(posedge mclk);
            tx_byte(c, 8'h81 ^ 8'(c * 19), c[0]);
        end
        @(posedge mclk) begin glob <= 1'b1; grp0 <= 1'b1; grp1 <= 1'b0; end
        repeat (4) @(posedge mclk);
        per = 12;
        tx_byte(0, 8'hc3, 1'b0);
        per = 25;
        tx_byte(1, 8'h96, 1'b0);
        rx_byte(1, 8'h3c);
        tx_byte(1, 8'h42, 1'b1);
        tx_byte(2, 8'h01, 1'b0);
        tx_byte(2, 8'h80, 1'b1);
        cmp({14'h0000, rdy_a[0], done_a[0]}, 16'h0000);
        end_sim();
    end
endmodule : serial_link_engine_tb
